// [rtl/fbc_pkg.sv]
// constants and types for the four-bit core instruction executor
package fbc_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int FBC_ADDR_W = 5;
    localparam int FBC_DATA_W = 32;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [4:0] FBC_OFF_INSTR = 5'h00;
    localparam logic [4:0] FBC_OFF_CORE = 5'h04;
    localparam logic [4:0] FBC_OFF_PROG = 5'h08;
    localparam logic [4:0] FBC_OFF_OUTS = 5'h0C;
    localparam logic [4:0] FBC_OFF_RAM = 5'h10;

    // ------------------------------------------------------------
    // axi responses
    // ------------------------------------------------------------
    localparam logic [1:0] FBC_RESP_OKAY = 2'h0;
    localparam logic [1:0] FBC_RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] FBC_OP_FILE_INV = 8'h00;
    localparam logic [7:0] FBC_OP_ADD8 = 8'h01;
    localparam logic [7:0] FBC_OP_ADD10 = 8'h05;
    localparam logic [7:0] FBC_OP_ACC_DEC = 8'h07;
    localparam logic [7:0] FBC_OP_KEY_TEST = 8'h09;
    localparam logic [7:0] FBC_OP_DEC_ZERO = 8'h0B;
    localparam logic [7:0] FBC_OP_LINE_LOW = 8'h0C;
    localparam logic [7:0] FBC_OP_ACC_INC = 8'h0E;
    localparam logic [7:0] FBC_OP_SUB_EXIT = 8'h0F;
    localparam logic [7:0] FBC_OP_MEM_TEST = 8'h26;
    localparam logic [7:0] FBC_OP_MEM_SUB_ACC = 8'h27;
    localparam logic [7:0] FBC_OP_MEM_INC = 8'h28;
    localparam logic [7:0] FBC_OP_MEM_DEC = 8'h2A;
    localparam logic [7:0] FBC_OP_PTR_DEC = 8'h2C;
    localparam logic [3:0] FBC_OP_SEG_LOAD_HI = 4'h1;
    localparam logic [5:0] FBC_OP_BIT_ZERO_HI = 6'h0D;
    localparam logic [5:0] FBC_OP_FILE_LOAD_HI = 6'h0F;

    // ------------------------------------------------------------
    // constants of the adder and timing
    // ------------------------------------------------------------
    localparam logic [3:0] FBC_EIGHT = 4'h8;
    localparam logic [3:0] FBC_TEN = 4'hA;
    localparam logic [3:0] FBC_ONE = 4'h1;
    localparam int FBC_EXEC_CYCLES = 6;
    localparam logic [2:0] FBC_EXEC_LAST = 3'(FBC_EXEC_CYCLES - 1);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic {
        FBC_IDLE = 1'b0,
        FBC_EXEC = 1'b1
    } fbc_state_type;

    typedef struct packed {
        fbc_state_type state;
        logic [2:0] cnt;
        logic [7:0] op;
        logic [3:0] acc;
        logic [3:0] ptr_y;
        logic [2:0] file_x;
        logic status;
        logic subroutine_flag;
        logic [5:0] pc;
        logic [3:0] active_rom_segment;
        logic [3:0] pending_rom_segment;
        logic [5:0] return_save_register;
        logic [4:0] output_decoder_input_latch;
        logic [15:0] r_lines;
        logic [3:0] key_s1;
        logic [3:0] key_s2;
        logic [3:0] key_s3;
        logic [3:0] key_stable;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [127:0][3:0] ram;
    } fbc_regs_type;

    localparam fbc_regs_type FBC_REGS_RST = '0;

endpackage

// [rtl/fbc_core.sv]
// instruction executor of the four-bit core with an axi4-lite port
// Operation
// - add eight to accumulator, keep four bits, carry into status
// - add ten to accumulator, keep four bits, carry into status
// - taken jump loads pc; segment copied only when flag clear
// - conditional jump lasts six clock cycles, taken or not
// - subroutine entry with status zero falls through
// - entry with flag set only loads pc inside segment
// - entry with flag clear swaps segments, saves pc+1, sets flag
// - decoder input clear zeroes five latch bits, status one
// - file select invert complements file select, status one
// - accumulator decrement, status on no borrow, zero wraps to 15
// - memory minus one into accumulator, memory kept, status on no borrow
// - pointer decrement, zero borrows and clears status
// - memory plus one into accumulator, carry into status
// - key test sets status when any key line is high
// - segment buffer load copies constant field, status one
// - file select load copies bit field, status one
// - memory test clears status on zero word, sets otherwise
// - bit clear zeroes chosen bit of addressed word, status one
// - accumulator increment wraps and leaves status one
// - all other instructions but memory minus accumulator (status on no borrow) leave status set to one
`timescale 1ns/100ps
module fbc_core (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [fbc_pkg::FBC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [fbc_pkg::FBC_DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [fbc_pkg::FBC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [fbc_pkg::FBC_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [3:0] key_in,
    output logic [15:0] r_lines,
    output logic [4:0] output_decoder_input_latch
);
    import fbc_pkg::*;

    fbc_regs_type r;
    fbc_regs_type next_r;

    // --------------------
    // helpers
    // --------------------
    // bit 4 of the result is the carry
    function automatic logic [4:0] fbc_add4(
        input logic [3:0] a,
        input logic [3:0] b
    );
        return {1'b0, a} + {1'b0, b};
    endfunction

    // bit 4 of the result is the borrow
    function automatic logic [4:0] fbc_sub4(
        input logic [3:0] a,
        input logic [3:0] b
    );
        return {1'b0, a} - {1'b0, b};
    endfunction

    function automatic logic fbc_mapped(input logic [4:0] off);
        return off == FBC_OFF_INSTR || off == FBC_OFF_CORE ||
            off == FBC_OFF_PROG || off == FBC_OFF_OUTS ||
            off == FBC_OFF_RAM;
    endfunction

    function automatic logic [31:0] fbc_read(
        input fbc_regs_type q,
        input logic [4:0] off
    );
        logic [31:0] d;
        d = 32'h0000_0000;
        case (off)
            FBC_OFF_INSTR: begin
                d[7:0] = q.op;
                d[8] = q.state == FBC_EXEC;
            end
            FBC_OFF_CORE: begin
                d[3:0] = q.acc;
                d[7:4] = q.ptr_y;
                d[10:8] = q.file_x;
                d[11] = q.status;
                d[12] = q.subroutine_flag;
                d[16:13] = q.key_stable;
            end
            FBC_OFF_PROG: begin
                d[5:0] = q.pc;
                d[9:6] = q.active_rom_segment;
                d[13:10] = q.pending_rom_segment;
                d[19:14] = q.return_save_register;
            end
            FBC_OFF_OUTS: begin
                d[4:0] = q.output_decoder_input_latch;
                d[31:16] = q.r_lines;
            end
            FBC_OFF_RAM: begin
                d[3:0] = q.ram[{q.file_x, q.ptr_y}];
            end
            default: begin
                d = 32'h0000_0000;
            end
        endcase
        return d;
    endfunction

    function automatic logic [31:0] fbc_merge(
        input logic [31:0] old,
        input logic [31:0] wdat,
        input logic [3:0] strb
    );
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return (old & ~m) | (wdat & m);
    endfunction

    // --------------------
    // next state
    // --------------------
    always_comb begin
        logic [6:0] idx;
        logic [3:0] mem;
        logic [4:0] res;
        logic [4:0] waddr;
        logic [4:0] raddr;
        logic [31:0] w;
        logic busy;
        idx = {r.file_x, r.ptr_y};
        mem = r.ram[idx];
        res = 5'h00;
        waddr = {s_axi_awaddr[4:2], 2'h0};
        raddr = {s_axi_araddr[4:2], 2'h0};
        w = 32'h0000_0000;
        busy = r.state == FBC_EXEC;
        next_r = r;
        next_r.awready = 1'b0;
        next_r.wready = 1'b0;
        next_r.arready = 1'b0;

        // key lines are asynchronous; accept only a settled pattern
        next_r.key_s1 = key_in;
        next_r.key_s2 = r.key_s1;
        next_r.key_s3 = r.key_s2;
        if (r.key_s2 == r.key_s3) begin
            next_r.key_stable = r.key_s3;
        end

        // --------------------
        // execution; every opcode takes the same six cycles
        // --------------------
        case (r.state)
            FBC_IDLE: begin
                next_r.cnt = 3'h0;
            end
            FBC_EXEC: begin
                if (r.cnt != 3'h0) begin
                    next_r.cnt = r.cnt - 3'h1;
                end else begin
                    next_r.state = FBC_IDLE;
                    next_r.status = 1'b1;
                    next_r.pc = r.pc + 6'h01;
                    if (r.op[7]) begin
                        if (r.status && !r.op[6]) begin
                            next_r.pc = r.op[5:0];
                            if (!r.subroutine_flag) begin
                                next_r.active_rom_segment =
                                    r.pending_rom_segment;
                            end
                        end else if (r.status) begin
                            next_r.pc = r.op[5:0];
                            if (!r.subroutine_flag) begin
                                next_r.active_rom_segment =
                                    r.pending_rom_segment;
                                next_r.pending_rom_segment =
                                    r.active_rom_segment;
                                next_r.return_save_register =
                                    r.pc + 6'h01;
                                next_r.subroutine_flag = 1'b1;
                            end
                        end
                    end else begin
                        case (r.op)
                            FBC_OP_ADD8: begin
                                res = fbc_add4(r.acc, FBC_EIGHT);
                                next_r.acc = res[3:0];
                                next_r.status = res[4];
                            end
                            FBC_OP_ADD10: begin
                                res = fbc_add4(r.acc, FBC_TEN);
                                next_r.acc = res[3:0];
                                next_r.status = res[4];
                            end
                            FBC_OP_SUB_EXIT: begin
                                next_r.active_rom_segment =
                                    r.pending_rom_segment;
                                next_r.subroutine_flag = 1'b0;
                                if (r.subroutine_flag) begin
                                    next_r.pc =
                                        r.return_save_register;
                                end
                            end
                            FBC_OP_DEC_ZERO: begin
                                next_r.output_decoder_input_latch =
                                    5'h00;
                            end
                            FBC_OP_FILE_INV: begin
                                next_r.file_x = ~r.file_x;
                            end
                            FBC_OP_ACC_DEC: begin
                                res = fbc_sub4(r.acc, FBC_ONE);
                                next_r.acc = res[3:0];
                                next_r.status = ~res[4];
                            end
                            FBC_OP_MEM_DEC: begin
                                res = fbc_sub4(mem, FBC_ONE);
                                next_r.acc = res[3:0];
                                next_r.status = ~res[4];
                            end
                            FBC_OP_PTR_DEC: begin
                                res = fbc_sub4(r.ptr_y, FBC_ONE);
                                next_r.ptr_y = res[3:0];
                                next_r.status = ~res[4];
                            end
                            FBC_OP_MEM_INC: begin
                                res = fbc_add4(mem, FBC_ONE);
                                next_r.acc = res[3:0];
                                next_r.status = res[4];
                            end
                            FBC_OP_KEY_TEST: begin
                                next_r.status = |r.key_stable;
                            end
                            FBC_OP_MEM_TEST: begin
                                next_r.status = |mem;
                            end
                            FBC_OP_LINE_LOW: begin
                                next_r.r_lines[r.ptr_y] = 1'b0;
                            end
                            FBC_OP_MEM_SUB_ACC: begin
                                res = fbc_sub4(mem, r.acc);
                                next_r.acc = res[3:0];
                                next_r.status = ~res[4];
                            end
                            FBC_OP_ACC_INC: begin
                                res = fbc_add4(r.acc, FBC_ONE);
                                next_r.acc = res[3:0];
                            end
                            default: begin
                                if (r.op[7:4] == FBC_OP_SEG_LOAD_HI) begin
                                    next_r.pending_rom_segment =
                                        r.op[3:0];
                                end
                                if (r.op[7:2] == FBC_OP_FILE_LOAD_HI) begin
                                    next_r.file_x = {1'b0, r.op[1:0]};
                                end
                                if (r.op[7:2] == FBC_OP_BIT_ZERO_HI) begin
                                    next_r.ram[idx][r.op[1:0]] =
                                        1'b0;
                                end
                            end
                        endcase
                    end
                end
            end
            default: begin
                next_r.state = FBC_IDLE;
            end
        endcase

        // --------------------
        // write channel: address and data are taken together
        // --------------------
        if (r.bvalid && s_axi_bready) begin
            next_r.bvalid = 1'b0;
        end
        if (s_axi_awvalid && s_axi_wvalid && !r.bvalid && !r.awready) begin
            next_r.awready = 1'b1;
            next_r.wready = 1'b1;
        end
        if (r.awready) begin
            next_r.bvalid = 1'b1;
            next_r.bresp = FBC_RESP_OKAY;
            w = fbc_merge(fbc_read(r, waddr), s_axi_wdata, s_axi_wstrb);
            // state may not change under a running instruction
            if (busy || !fbc_mapped(waddr)) begin
                next_r.bresp = FBC_RESP_SLVERR;
            end else begin
                case (waddr)
                    FBC_OFF_INSTR: begin
                        next_r.op = w[7:0];
                        next_r.state = FBC_EXEC;
                        next_r.cnt = FBC_EXEC_LAST;
                    end
                    FBC_OFF_CORE: begin
                        next_r.acc = w[3:0];
                        next_r.ptr_y = w[7:4];
                        next_r.file_x = w[10:8];
                        next_r.status = w[11];
                        next_r.subroutine_flag = w[12];
                    end
                    FBC_OFF_PROG: begin
                        next_r.pc = w[5:0];
                        next_r.active_rom_segment = w[9:6];
                        next_r.pending_rom_segment = w[13:10];
                        next_r.return_save_register = w[19:14];
                    end
                    FBC_OFF_OUTS: begin
                        next_r.output_decoder_input_latch = w[4:0];
                        next_r.r_lines = w[31:16];
                    end
                    FBC_OFF_RAM: begin
                        next_r.ram[idx] = w[3:0];
                    end
                    default: begin
                        next_r.bresp = FBC_RESP_SLVERR;
                    end
                endcase
            end
        end

        // --------------------
        // read channel
        // --------------------
        if (r.rvalid && s_axi_rready) begin
            next_r.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !r.rvalid && !r.arready) begin
            next_r.arready = 1'b1;
        end
        if (r.arready) begin
            next_r.rvalid = 1'b1;
            next_r.rdata = fbc_read(r, raddr);
            next_r.rresp = fbc_mapped(raddr) ? FBC_RESP_OKAY :
                FBC_RESP_SLVERR;
        end

        if (!aresetn) begin
            next_r = FBC_REGS_RST;
        end
    end

    always_ff @(posedge aclk) begin
        r <= next_r;
    end

    // --------------------
    // outputs
    // --------------------
    assign s_axi_awready = r.awready;
    assign s_axi_wready = r.wready;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = r.arready;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rdata = r.rdata;
    assign s_axi_rresp = r.rresp;
    assign r_lines = r.r_lines;
    assign output_decoder_input_latch = r.output_decoder_input_latch;

endmodule

// [sim/fbc_core_props.sv]
// port assertions for the four-bit core instruction executor
`timescale 1ns/100ps
module fbc_core_props import fbc_pkg::*; (
    input logic aclk,
    input logic aresetn,
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic [fbc_pkg::FBC_DATA_W-1:0] s_axi_rdata,
    input logic [1:0] s_axi_rresp,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic [15:0] r_lines,
    input logic [4:0] output_decoder_input_latch
);
    // --------------------
    // bus handshakes
    // --------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // a lone address or data beat must never be taken
    property p_aw_w_pair;
        s_axi_awready |-> s_axi_wready && s_axi_awvalid && s_axi_wvalid;
    endproperty
    a_aw_w_pair: assert property (p_aw_w_pair) else $error("aw/w split");
    property p_wr_answer;
        s_wr_take |=> s_axi_bvalid;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("no bvalid");
    property p_bvalid_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bvalid_hold: assert property (p_bvalid_hold) else $error("b dropped");
    property p_bvalid_drop;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_bvalid_drop: assert property (p_bvalid_drop) else $error("b repeats");
    property p_rd_answer;
        s_rd_take |=> s_axi_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("no rvalid");
    property p_rvalid_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
            && $stable(s_axi_rresp);
    endproperty
    a_rvalid_hold: assert property (p_rvalid_hold) else $error("r dropped");
    property p_rd_err_zero;
        s_axi_rvalid && s_axi_rresp == FBC_RESP_SLVERR |-> s_axi_rdata == '0;
    endproperty
    a_rd_err_zero: assert property (p_rd_err_zero) else $error("err data");
    // --------------------
    // output latches change only by a write or an instruction commit
    // --------------------
    property p_latch_cause;
        $changed(output_decoder_input_latch) |-> !$past(aresetn)
            || $past(s_axi_awready) || (output_decoder_input_latch == 5'h00
            && ($past(s_axi_awready, 6) || $past(s_axi_awready, 7)));
    endproperty
    a_latch_cause: assert property (p_latch_cause) else $error("latch");
    // an instruction may only pull one line low
    property p_lines_cause;
        $changed(r_lines) |-> !$past(aresetn) || $past(s_axi_awready)
            || ($countones($past(r_lines) ^ r_lines) == 1
            && (r_lines & ~$past(r_lines)) == 16'h0000
            && ($past(s_axi_awready, 6) || $past(s_axi_awready, 7)));
    endproperty
    a_lines_cause: assert property (p_lines_cause) else $error("lines");
endmodule

bind fbc_core fbc_core_props u_props (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .r_lines(r_lines),
    .output_decoder_input_latch(output_decoder_input_latch)
);

// [sim/four_bit_core_instr_exec_bench.sv]
// self-checking bench for the four-bit core instruction executor
`timescale 1ns/100ps
module four_bit_core_instr_exec_bench;
    import fbc_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [4:0] awaddr = 5'h00, araddr = 5'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata, rv;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rr;
    logic [3:0] key_in = 4'h0;
    logic [15:0] r_lines;
    logic [4:0] output_decoder_input_latch;
    int miscompares = 0, check_count = 0;

    always #12.5 aclk = ~aclk;

    fbc_core DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .key_in(key_in), .r_lines(r_lines),
        .output_decoder_input_latch(output_decoder_input_latch));

    // --------------------
    // bus tasks
    // --------------------
    task chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            $display("ERROR at %0t: got %h expected %h", $time, g, e);
            miscompares++;
        end
    endtask
    // each channel drops valid only at the edge that saw its ready
    task wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] e);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk(32'(bresp), 32'(e));
    endtask
    task rd(input logic [4:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rv = rdata;
        rr = rresp;
        rready <= 1'b0;
    endtask
    // the refused write proves the instruction is still running
    task exec(input logic [7:0] op);
        wr(FBC_OFF_INSTR, {24'h0, op}, FBC_RESP_OKAY);
        wr(FBC_OFF_CORE, 32'hFFFF_FFFF, FBC_RESP_SLVERR);
        do rd(FBC_OFF_INSTR); while (rv[8] !== 1'b0);
    endtask
    task run(input logic [7:0] op, input logic [15:0] ci, input logic [3:0] ri,
        input logic [19:0] pi, input logic [15:0] ec, input logic [3:0] er,
        input logic [19:0] ep);
        wr(FBC_OFF_CORE, {16'h0, ci}, FBC_RESP_OKAY);
        wr(FBC_OFF_RAM, {28'h0, ri}, FBC_RESP_OKAY);
        wr(FBC_OFF_PROG, {12'h0, pi}, FBC_RESP_OKAY);
        exec(op);
        rd(FBC_OFF_CORE);
        chk(32'(rv[12:0]), 32'(ec));
        rd(FBC_OFF_RAM);
        chk(32'(rv[3:0]), 32'(er));
        rd(FBC_OFF_PROG);
        chk(32'(rv[19:0]), 32'(ep));
    endtask
    task alu(input logic [7:0] op, input logic [15:0] ci, input logic [3:0] ri,
        input logic [15:0] ec, input logic [3:0] er);
        run(op, ci, ri, 20'h0_0000, ec, er, 20'h0_0001);
    endtask
    task fl(input logic [7:0] op, input logic [15:0] ci, input logic [19:0] pi,
        input logic [15:0] ec, input logic [19:0] ep);
        run(op, ci, 4'h0, pi, ec, 4'h0, ep);
    endtask
    task report_and_stop();
        $display("comparisons %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // --------------------
    // tests
    // --------------------
    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        report_and_stop();
    end
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(FBC_OFF_CORE);
        chk(rv, 32'h0000_0000);
        rd(5'h14);
        chk(32'(rr), 32'(FBC_RESP_SLVERR));
        chk(rv, 32'h0000_0000);
        wr(5'h1C, 32'hFFFF_FFFF, FBC_RESP_SLVERR);
        $display("test bus done");
        alu(8'h01, 16'h0009, 4'h0, 16'h0801, 4'h0);
        alu(8'h01, 16'h0806, 4'h0, 16'h000E, 4'h0);
        alu(8'h05, 16'h0009, 4'h0, 16'h0803, 4'h0);
        alu(8'h05, 16'h0803, 4'h0, 16'h000D, 4'h0);
        alu(8'h07, 16'h0800, 4'h0, 16'h000F, 4'h0);
        alu(8'h07, 16'h0009, 4'h0, 16'h0808, 4'h0);
        alu(8'h2A, 16'h0800, 4'h0, 16'h000F, 4'h0);
        alu(8'h2A, 16'h0350, 4'h9, 16'h0B58, 4'h9);
        alu(8'h28, 16'h0000, 4'hF, 16'h0800, 4'hF);
        alu(8'h28, 16'h0800, 4'h2, 16'h0003, 4'h2);
        alu(8'h26, 16'h0805, 4'h0, 16'h0005, 4'h0);
        alu(8'h26, 16'h0005, 4'h7, 16'h0805, 4'h7);
        alu(8'h27, 16'h0006, 4'hA, 16'h0804, 4'hA);
        alu(8'h27, 16'h080C, 4'h4, 16'h0008, 4'h4);
        alu(8'h27, 16'h0005, 4'h5, 16'h0800, 4'h5);
        alu(8'h0E, 16'h000F, 4'h0, 16'h0800, 4'h0);
        alu(8'h2C, 16'h0800, 4'h0, 16'h00F0, 4'h0);
        alu(8'h2C, 16'h0060, 4'h0, 16'h0850, 4'h0);
        alu(8'h00, 16'h0200, 4'h0, 16'h0D00, 4'h0);
        alu(8'h3E, 16'h0500, 4'h0, 16'h0A00, 4'h0);
        alu(8'h37, 16'h0000, 4'hF, 16'h0800, 4'h7);
        alu(8'h34, 16'h0000, 4'hF, 16'h0800, 4'hE);
        alu(8'h09, 16'h0800, 4'h0, 16'h0000, 4'h0);
        key_in <= 4'h5;
        alu(8'h09, 16'h0000, 4'h0, 16'h0800, 4'h0);
        $display("test arithmetic done");
        wr(FBC_OFF_OUTS, 32'hFFFF_001F, FBC_RESP_OKAY);
        alu(8'h0B, 16'h0000, 4'h0, 16'h0800, 4'h0);
        chk(32'(output_decoder_input_latch), 32'h0000_0000);
        alu(8'h0C, 16'h0050, 4'h0, 16'h0850, 4'h0);
        chk(32'(r_lines), 32'h0000_FFDF);
        $display("test outputs done");
        fl(8'hA0, 16'h0000, 20'h0_1483, 16'h0800, 20'h0_1484);
        fl(8'hA0, 16'h0800, 20'h0_1483, 16'h0800, 20'h0_1560);
        fl(8'hA0, 16'h1800, 20'h0_1483, 16'h1800, 20'h0_14A0);
        fl(8'hE0, 16'h0000, 20'h0_1483, 16'h0800, 20'h0_1484);
        fl(8'hE0, 16'h0800, 20'h0_1483, 16'h1800, 20'h1_0960);
        fl(8'hE0, 16'h1800, 20'h0_1483, 16'h1800, 20'h0_14A0);
        fl(8'h0F, 16'h1800, 20'h2_5483, 16'h0800, 20'h2_5549);
        fl(8'h0F, 16'h0800, 20'h0_1483, 16'h0800, 20'h0_1544);
        fl(8'h17, 16'h0000, 20'h0_1483, 16'h0800, 20'h0_1C84);
        fl(8'h02, 16'h0003, 20'h0_003F, 16'h0803, 20'h0_0000);
        $display("test flow done");
        report_and_stop();
    end
endmodule
